// file: hdl/lcd_ctrl_strap_host_select.sv
// Strap decode, host port selection and pin mapping for the LCD core
`timescale 1ns/1ps
module lcd_ctrl_strap_host_select (
  input  wire logic       CLOCK,
  input  wire logic       RESET_N,
  input  wire logic       EXT_RESET_N,
  input  wire logic       EXTENSION_STRAP,
  input  wire logic       PAR_SER_STRAP,
  input  wire logic       SERIAL_KIND_STRAP,
  input  wire logic [1:0] GLYPH_SPLIT_STRAPS,
  input  wire logic       COMMON_DIR_STRAP,
  input  wire logic       SEGMENT_DIR_STRAP,
  input  wire logic [1:0] BIAS_SOURCE_STRAPS,
  input  wire logic       CLOCK_SOURCE_STRAP,
  input  wire logic       REG_SELECT,
  input  wire logic       READ_WRITE,
  input  wire logic       BUS_STROBE,
  input  wire logic       CHIP_SEL_N,
  input  wire logic [7:0] HOST_DATA_IN,
  output logic      [7:0] HOST_DATA_OUT,
  output logic      [7:0] HOST_DATA_OE_N,
  input  wire logic       FOUR_BIT_BUS,
  input  wire logic       BUSY,
  input  wire logic [6:0] ADDR_COUNTER,
  input  wire logic [7:0] READ_DATA,
  input  wire logic       BOOST_REQ,
  input  wire logic       DOUBLE_FONT_REQ,
  input  wire logic       DUTY_HALF,
  input  wire logic [3:0] SCAN_ROW,
  input  wire logic [6:0] SCAN_COL,
  input  wire logic [7:0] CHAR_CODE,
  input  wire logic [6:0] DDRAM_ADDR,
  input  wire logic [5:0] GLYPH_RAM_ADDR,
  output logic            CORE_RESET,
  output logic            INSTR_WR,
  output logic            DATA_WR,
  output logic            DATA_RD,
  output logic      [7:0] WR_DATA,
  output logic            I2C_SDA,
  output logic            I2C_SCL,
  output logic            PORT_INVALID,
  output logic            SER4_SEL,
  output logic            I2C_SEL,
  output logic            PAR_SEL,
  output logic            EXT_MODE,
  output logic      [8:0] ROM_GLYPHS,
  output logic      [3:0] RAM_GLYPHS,
  output logic            GLYPH_FROM_RAM,
  output logic      [3:0] COM_ROW,
  output logic      [6:0] SEG_COL,
  output logic     [15:0] COM_NONSEL,
  output logic            INT_OSC_SEL,
  output logic      [1:0] BIAS_SEL,
  output logic            BIAS_INVALID,
  output logic            BOOST_ON,
  output logic            ICON_RAM_EN,
  output logic            DOUBLE_FONT,
  output logic            OSC_TRIM_EN,
  output logic            CONTRAST_BY_INSTR,
  output logic            DDRAM_ADDR_OK,
  output logic            GLYPH_RAM_ADDR_OK
);
  // Row order from the common strap
  function automatic logic [3:0] map_row(input logic dir,
                                         input logic [3:0] r);
    map_row = dir ? r : lcd_cfg_pkg::ROW_LAST - r;
  endfunction

  // Column order from the segment strap
  function automatic logic [6:0] map_col(input logic dir,
                                         input logic [6:0] c);
    map_col = dir ? c : lcd_cfg_pkg::COL_LAST - c;
  endfunction

  // Pin synchronisers; only the second stage is read
  logic [13:0] pin_s1_r;  // First stage
  logic [13:0] pin_s2_r;  // Second stage
  logic [11:0] strap_s1_r;
  logic [11:0] strap_s2_r;
  wire  [13:0] pins = {EXT_RESET_N, REG_SELECT, READ_WRITE,
                       BUS_STROBE, CHIP_SEL_N, HOST_DATA_IN,
                       1'b0};
  wire  [11:0] straps = {EXTENSION_STRAP, PAR_SER_STRAP,
                         SERIAL_KIND_STRAP, GLYPH_SPLIT_STRAPS,
                         COMMON_DIR_STRAP, SEGMENT_DIR_STRAP,
                         BIAS_SOURCE_STRAPS, CLOCK_SOURCE_STRAP,
                         2'b00};

  // Data paths carry no reset, so straps survive to sampling
  always_ff @(posedge CLOCK) begin
    pin_s1_r   <= pins;
    pin_s2_r   <= pin_s1_r;
    strap_s1_r <= straps;
    strap_s2_r <= strap_s1_r;
  end

  wire       ext_rst_n_s = pin_s2_r[13];
  wire       rs_s        = pin_s2_r[12];
  wire       rw_s        = pin_s2_r[11];
  wire       strobe_s    = pin_s2_r[10];
  wire       cs_n_s      = pin_s2_r[9];
  wire [7:0] db_s        = pin_s2_r[8:1];

  // either reset source holds the block
  wire rst = ~RESET_N | ~ext_rst_n_s;

  // straps follow pins only while in reset
  logic [11:0] strap_r;
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      strap_r <= strap_s2_r;
    end
  end

  wire       ext_n    = strap_r[11];
  wire [1:0] port_sel = strap_r[10:9];
  wire [1:0] glyph    = strap_r[8:7];
  wire       com_dir  = strap_r[6];
  wire       seg_dir  = strap_r[5];
  wire [1:0] bias     = strap_r[4:3];
  wire       clk_src  = strap_r[2];

  // extension strap low enables extended set
  wire ext_on = ~ext_n;
  wire is_par = (port_sel == lcd_cfg_pkg::PORT_PAR68);
  wire is_ser = (port_sel == lcd_cfg_pkg::PORT_SER4);
  wire is_i2c = (port_sel == lcd_cfg_pkg::PORT_I2C);
  wire is_bad = (port_sel == lcd_cfg_pkg::PORT_BAD);

  logic [8:0] rom_n;
  logic [3:0] ram_n;
  always_comb begin
    case (glyph)
      2'h0: begin
        rom_n = lcd_cfg_pkg::ROM_SPLIT0;
        ram_n = lcd_cfg_pkg::RAM_SPLIT0;
      end
      2'h1: begin
        rom_n = lcd_cfg_pkg::ROM_SPLIT1;
        ram_n = lcd_cfg_pkg::RAM_SPLIT1;
      end
      2'h2: begin
        rom_n = lcd_cfg_pkg::ROM_SPLIT2;
        ram_n = lcd_cfg_pkg::RAM_SPLIT2;
      end
      default: begin
        rom_n = lcd_cfg_pkg::ROM_SPLIT3;
        ram_n = lcd_cfg_pkg::RAM_SPLIT3;
      end
    endcase
  end
  // Lowest codes go to the RAM glyphs
  wire from_ram = ({1'b0, CHAR_CODE} < {5'h00, ram_n});

  // upper commons idle at half duty
  wire [15:0] nonsel = DUTY_HALF ? 16'hFF00 : 16'h0000;
  wire follow  = (bias == lcd_cfg_pkg::BIAS_FOLLOW);
  wire bias_bd = follow & ~ext_on;

  // Configuration outputs, all registered
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      PORT_INVALID      <= 1'b0;
      SER4_SEL          <= 1'b0;
      I2C_SEL           <= 1'b0;
      PAR_SEL           <= 1'b0;
      EXT_MODE          <= 1'b0;
      ROM_GLYPHS        <= 9'h000;
      RAM_GLYPHS        <= 4'h0;
      GLYPH_FROM_RAM    <= 1'b0;
      COM_ROW           <= 4'h0;
      SEG_COL           <= 7'h00;
      COM_NONSEL        <= 16'h0000;
      INT_OSC_SEL       <= 1'b0;
      BIAS_SEL          <= 2'h0;
      BIAS_INVALID      <= 1'b0;
      BOOST_ON          <= 1'b0;
      ICON_RAM_EN       <= 1'b0;
      DOUBLE_FONT       <= 1'b0;
      OSC_TRIM_EN       <= 1'b0;
      CONTRAST_BY_INSTR <= 1'b0;
      DDRAM_ADDR_OK     <= 1'b0;
      GLYPH_RAM_ADDR_OK     <= 1'b0;
    end else begin
      PORT_INVALID      <= is_bad;
      SER4_SEL          <= is_ser;
      I2C_SEL           <= is_i2c;
      PAR_SEL           <= is_par;
      EXT_MODE          <= ext_on;
      ROM_GLYPHS        <= rom_n;
      RAM_GLYPHS        <= ram_n;
      GLYPH_FROM_RAM    <= from_ram;
      COM_ROW           <= map_row(com_dir, SCAN_ROW);
      SEG_COL           <= map_col(seg_dir, SCAN_COL);
      COM_NONSEL        <= nonsel;
      INT_OSC_SEL       <= clk_src;
      BIAS_SEL          <= bias;
      BIAS_INVALID      <= bias_bd;
      BOOST_ON          <= ext_on & BOOST_REQ;
      // icon RAM only in extension mode
      ICON_RAM_EN       <= ext_on;
      // tall font only in extension mode
      DOUBLE_FONT       <= ext_on & DOUBLE_FONT_REQ;
      // oscillator trim only in extension mode
      OSC_TRIM_EN       <= ext_on;
      CONTRAST_BY_INSTR <= ext_on & follow;
      DDRAM_ADDR_OK     <= DDRAM_ADDR <= lcd_cfg_pkg::DDRAM_LAST;
      GLYPH_RAM_ADDR_OK     <= GLYPH_RAM_ADDR <= lcd_cfg_pkg::GLYPH_RAM_LAST;
    end
  end

  // serial pins are the top two data pins
  ser4_if sif ();
  assign sif.en   = is_ser;
  assign sif.cs_n = cs_n_s;
  assign sif.sclk = db_s[6];
  assign sif.sdi  = db_s[7];
  assign sif.rs   = rs_s;

  ser4_shift u_ser (
    .clk (CLOCK),
    .rst (rst),
    .sif (sif)
  );

  // Parallel strobe edges; strobe ignored unless parallel
  logic   strobe_d_r;  // Last strobe level
  lcd_cfg_pkg::nib_t nib_r;  // 4-bit bus phase
  logic [3:0] hi_nib_r;      // High nibble held
  wire par_go   = is_par & ~cs_n_s;
  wire str_fall = par_go & strobe_d_r & ~strobe_s;
  // read when high, write when low
  wire par_rd   = par_go & strobe_s & rw_s;
  wire nib_low  = FOUR_BIT_BUS &
                  (nib_r == lcd_cfg_pkg::NIB_LOW);
  // Whole byte done on strobe fall
  wire byte_end = str_fall & (~FOUR_BIT_BUS | nib_low);
  // low nibble arrives on the high pins
  wire [7:0] par_byte = FOUR_BIT_BUS ?
                        {hi_nib_r, db_s[7:4]} : db_s;

  // select 0 reads busy and address
  wire [7:0] rd_word = rs_s ? READ_DATA : {BUSY, ADDR_COUNTER};
  wire [7:0] rd_pins = (FOUR_BIT_BUS & nib_low) ?
                       {rd_word[3:0], 4'h0} : rd_word;
  // low pins never driven in 4-bit mode
  wire [7:0] oe_mask = FOUR_BIT_BUS ? 8'h0F : 8'h00;

  // Nibble phase; restarts when 8-bit mode returns
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      // Strobe idles low; a high history here fakes a fall at release
      strobe_d_r <= 1'b0;
      nib_r      <= lcd_cfg_pkg::NIB_HIGH;
      hi_nib_r   <= 4'h0;
    end else begin
      strobe_d_r <= strobe_s;
      if (~FOUR_BIT_BUS) begin
        nib_r <= lcd_cfg_pkg::NIB_HIGH;
      end else if (str_fall) begin
        case (nib_r)
          lcd_cfg_pkg::NIB_HIGH: begin
            nib_r    <= lcd_cfg_pkg::NIB_LOW;
            hi_nib_r <= db_s[7:4];
          end
          lcd_cfg_pkg::NIB_LOW: nib_r <= lcd_cfg_pkg::NIB_HIGH;
          default: nib_r <= lcd_cfg_pkg::NIB_HIGH;
        endcase
      end
    end
  end

  // Access pulses toward the core
  wire wr_par = byte_end & ~rw_s;
  wire ser_go = sif.byte_stb;
  wire wr_rs  = ser_go ? sif.byte_rs : rs_s;
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      INSTR_WR <= 1'b0;
      DATA_WR  <= 1'b0;
      DATA_RD  <= 1'b0;
      WR_DATA  <= 8'h00;
    end else begin
      INSTR_WR <= (wr_par | ser_go) & ~wr_rs;
      DATA_WR  <= (wr_par | ser_go) & wr_rs;
      // Data read advances the core after a full byte
      DATA_RD  <= byte_end & rw_s & rs_s;
      if (ser_go) begin
        WR_DATA <= sif.byte_val;
      end else if (wr_par) begin
        WR_DATA <= par_byte;
      end
    end
  end

  // Pin drive; I2C acknowledge is left to the I2C engine
  always_ff @(posedge CLOCK) begin
    if (rst) begin
      HOST_DATA_OUT  <= lcd_cfg_pkg::DATA_RST;
      HOST_DATA_OE_N <= lcd_cfg_pkg::OE_N_RST;
      CORE_RESET     <= 1'b1;
      I2C_SDA        <= 1'b1;
      I2C_SCL        <= 1'b1;
    end else begin
      HOST_DATA_OUT  <= rd_pins;
      // busy flag rides on the top pin
      HOST_DATA_OE_N <= par_rd ? oe_mask : lcd_cfg_pkg::OE_N_RST;
      CORE_RESET     <= 1'b0;
      // I2C lines on the top two pins
      I2C_SDA        <= is_i2c ? db_s[7] : 1'b1;
      I2C_SCL        <= is_i2c ? db_s[6] : 1'b1;
    end
  end
endmodule

// file: common/lcd_cfg_pkg.sv
// Constants for strap decode and host port selection
package lcd_cfg_pkg;
  // Panel geometry
  localparam int unsigned NUM_COM     = 16;
  localparam int unsigned NUM_SEG     = 80;
  localparam logic [3:0]  ROW_LAST    = 4'hF;
  localparam logic [6:0]  COL_LAST    = 7'h4F;
  // Memory sizes
  localparam int unsigned DDRAM_BYTES = 80;
  localparam int unsigned GLYPH_RAM_BYTES = 64;
  localparam int unsigned ICON_BITS   = 80;
  localparam logic [6:0]  DDRAM_LAST  = 7'h4F;
  localparam logic [5:0]  GLYPH_RAM_LAST  = 6'h3F;
  // Interface strap codes {par_ser, serial_kind}
  localparam logic [1:0]  PORT_BAD    = 2'h0;
  localparam logic [1:0]  PORT_SER4   = 2'h1;
  localparam logic [1:0]  PORT_I2C    = 2'h2;
  localparam logic [1:0]  PORT_PAR68  = 2'h3;
  // Glyph split codes and counts
  localparam logic [8:0]  ROM_SPLIT0  = 9'h0F0;
  localparam logic [8:0]  ROM_SPLIT1  = 9'h0FA;
  localparam logic [8:0]  ROM_SPLIT2  = 9'h0F8;
  localparam logic [8:0]  ROM_SPLIT3  = 9'h100;
  localparam logic [3:0]  RAM_SPLIT0  = 4'h8;
  localparam logic [3:0]  RAM_SPLIT1  = 4'h6;
  localparam logic [3:0]  RAM_SPLIT2  = 4'h8;
  localparam logic [3:0]  RAM_SPLIT3  = 4'h0;
  // Bias source codes
  localparam logic [1:0]  BIAS_FOLLOW = 2'h0;
  localparam logic [1:0]  BIAS_R3K3   = 2'h1;
  localparam logic [1:0]  BIAS_R9K6   = 2'h2;
  localparam logic [1:0]  BIAS_EXTR   = 2'h3;
  // Reset values of host pins
  localparam logic [7:0]  DATA_RST    = 8'h00;
  localparam logic [7:0]  OE_N_RST    = 8'hFF;
  // Serial word length
  localparam logic [2:0]  SER_LAST    = 3'h7;
  // Nibble phase of the 4-bit bus
  typedef enum logic {NIB_HIGH, NIB_LOW} nib_t;
endpackage

// file: common/ser4_if.sv
// Signals between the pin front end and the serial shifter
`timescale 1ns/1ps
interface ser4_if;
  logic       en;        // 4-wire serial selected
  logic       cs_n;      // Synced chip select
  logic       sclk;      // Synced serial clock
  logic       sdi;       // Synced serial data
  logic       rs;        // Synced register select
  logic       byte_stb;  // Byte complete, one cycle
  logic [7:0] byte_val;  // Received byte
  logic       byte_rs;   // Register select of that byte
  modport front (output en, cs_n, sclk, sdi, rs,
                 input byte_stb, byte_val, byte_rs);
  modport rx    (input en, cs_n, sclk, sdi, rs,
                 output byte_stb, byte_val, byte_rs);
endinterface

// file: hdl/ser4_shift.sv
// Four-wire serial receiver: shifts bytes in MSB first
`timescale 1ns/1ps
module ser4_shift (
  input  wire logic clk,
  input  wire logic rst,
  ser4_if.rx        sif
);
  logic [6:0] shift_r;  // Bits received so far
  logic [2:0] cnt_r;    // Bit counter
  logic       cs_d_r;   // Last chip select level
  logic       sclk_d_r; // Last serial clock level
  logic       stb_r;    // Byte strobe
  logic [7:0] byte_r;   // Completed byte
  logic       rs_r;     // Register select at last bit

  wire cs_fall  = cs_d_r & ~sif.cs_n;
  wire sclk_up  = ~sclk_d_r & sif.sclk;
  // Shift only while selected and in serial mode
  wire take_bit = sif.en & ~sif.cs_n & sclk_up;
  wire last_bit = (cnt_r == lcd_cfg_pkg::SER_LAST);

  assign sif.byte_stb = stb_r;
  assign sif.byte_val = byte_r;
  assign sif.byte_rs  = rs_r;

  // Edge history; idles high like the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b1;
    end else begin
      cs_d_r   <= sif.cs_n;
      sclk_d_r <= sif.sclk;
    end
  end

  // Shift and count; a fresh select restarts the word
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r <= 7'h00;
      cnt_r   <= 3'h0;
      stb_r   <= 1'b0;
      byte_r  <= 8'h00;
      rs_r    <= 1'b0;
    end else begin
      stb_r <= 1'b0;
      if (cs_fall) begin
        shift_r <= 7'h00;
        cnt_r   <= 3'h0;
      end else if (take_bit) begin
        shift_r <= {shift_r[5:0], sif.sdi};
        cnt_r   <= cnt_r + 3'h1;
        if (last_bit) begin
          stb_r  <= 1'b1;
          byte_r <= {shift_r, sif.sdi};
          rs_r   <= sif.rs;
        end
      end
    end
  end
endmodule

// file: testbench/lcd_strap_sva.sv
// Checker for strap decode and host port selection
`timescale 1ns/1ps
module lcd_strap_sva (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic        DUTY_HALF,
  input wire logic        FOUR_BIT_BUS,
  input wire logic  [3:0] SCAN_ROW,
  input wire logic  [6:0] SCAN_COL,
  input wire logic  [7:0] HOST_DATA_OE_N,
  input wire logic        CORE_RESET,
  input wire logic        INSTR_WR,
  input wire logic        DATA_WR,
  input wire logic        I2C_SDA,
  input wire logic        I2C_SCL,
  input wire logic        PORT_INVALID,
  input wire logic        SER4_SEL,
  input wire logic        I2C_SEL,
  input wire logic        PAR_SEL,
  input wire logic        EXT_MODE,
  input wire logic  [8:0] ROM_GLYPHS,
  input wire logic  [3:0] RAM_GLYPHS,
  input wire logic  [3:0] COM_ROW,
  input wire logic  [6:0] SEG_COL,
  input wire logic [15:0] COM_NONSEL,
  input wire logic  [1:0] BIAS_SEL,
  input wire logic        BOOST_ON,
  input wire logic        ICON_RAM_EN,
  input wire logic        DOUBLE_FONT,
  input wire logic        OSC_TRIM_EN,
  input wire logic        CONTRAST_BY_INSTR
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic run_r;                      // Core was running at the last edge
  wire  run = run_r && !CORE_RESET; // Two settled cycles, so $past is valid
  // Run tracker; an external reset also clears it
  always_ff @(posedge CLOCK) run_r <= RESET_N && !CORE_RESET;
  a_reset_release: assert property ($rose(RESET_N) |-> CORE_RESET
    ##1 (!CORE_RESET && HOST_DATA_OE_N == 8'hFF))
    else $error("core reset not released cleanly");
  a_port_onehot: assert property (run |->
    $onehot({PORT_INVALID, SER4_SEL, I2C_SEL, PAR_SEL}))
    else $error("port selection not one-hot");
  a_pulse_single: assert property ((INSTR_WR || DATA_WR) |->
    !(INSTR_WR && DATA_WR) ##1 !(INSTR_WR || DATA_WR))
    else $error("write pulse too long or doubled");
  a_pulse_port: assert property ((INSTR_WR || DATA_WR) |->
    (SER4_SEL || PAR_SEL)) else $error("write from unselected port");
  a_com_order: assert property (run |->
    (COM_ROW ^ $past(SCAN_ROW)) inside {4'h0, 4'hF})
    else $error("common mapping wrong");
  a_seg_order: assert property (run |-> SEG_COL == $past(SCAN_COL) ||
    SEG_COL == lcd_cfg_pkg::COL_LAST - $past(SCAN_COL))
    else $error("segment mapping wrong");
  a_nonsel_duty: assert property (run |->
    COM_NONSEL == ($past(DUTY_HALF) ? 16'hFF00 : 16'h0000))
    else $error("non-selected commons wrong");
  a_normal_limits: assert property (run && !EXT_MODE |-> !(BOOST_ON ||
    ICON_RAM_EN || DOUBLE_FONT || OSC_TRIM_EN || CONTRAST_BY_INSTR))
    else $error("extended feature in normal mode");
  a_contrast_src: assert property (run |-> CONTRAST_BY_INSTR ==
    (EXT_MODE && BIAS_SEL == lcd_cfg_pkg::BIAS_FOLLOW))
    else $error("contrast source wrong");
  a_config_frozen: assert property (run |-> $stable({PORT_INVALID,
    SER4_SEL, I2C_SEL, PAR_SEL, EXT_MODE, ROM_GLYPHS, RAM_GLYPHS, BIAS_SEL}))
    else $error("configuration changed while running");
  a_serial_quiet: assert property (run && !PAR_SEL |->
    HOST_DATA_OE_N == 8'hFF) else $error("pins driven outside parallel");
  a_nibble_pins: assert property (run && $past(FOUR_BIT_BUS) |->
    HOST_DATA_OE_N[3:0] == 4'hF) else $error("low pins driven in 4-bit");
  a_i2c_idle: assert property (run && !I2C_SEL |-> I2C_SDA && I2C_SCL)
    else $error("two-wire lines not idle");
endmodule
bind lcd_ctrl_strap_host_select lcd_strap_sva chk_u (.*);

// file: testbench/host_model.sv
// Host processor model for the parallel and serial pins
`timescale 1ns/1ps
module host_model (
  input  wire logic       CLOCK,
  input  wire logic [7:0] HOST_DATA_OUT,
  input  wire logic [7:0] HOST_DATA_OE_N,
  output logic            REG_SELECT,
  output logic            READ_WRITE,
  output logic            BUS_STROBE,
  output logic            CHIP_SEL_N,
  output logic      [7:0] HOST_DATA_IN
);
  logic [7:0] hd_r;  // Level the host puts on the pins
  logic       hd_en; // Host drives the pins
  // Pull-ups lift every pin that nobody drives
  assign HOST_DATA_IN = (~HOST_DATA_OE_N & HOST_DATA_OUT) |
    (HOST_DATA_OE_N & (hd_en ? hd_r : 8'hFF));
  initial begin
    {REG_SELECT, READ_WRITE, BUS_STROBE, CHIP_SEL_N} = 4'h1;
    hd_r = 8'h00;
    hd_en = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  // One strobed access; inputs change only at falling edges
  task automatic par(input logic cs_n, rs, rw, input logic [7:0] d,
                     output logic [7:0] q, output logic [7:0] oe);
    // select and direction steady across strobe
    REG_SELECT = rs;
    READ_WRITE = rw;
    CHIP_SEL_N = cs_n;
    BUS_STROBE = 1'b0;
    hd_r = d;
    hd_en = !rw;
    tick(4);
    BUS_STROBE = 1'b1;
    tick(3);
    q = HOST_DATA_OUT;
    oe = HOST_DATA_OE_N;
    tick(1);
    BUS_STROBE = 1'b0;
    tick(6);
    CHIP_SEL_N = 1'b1;
    hd_en = 1'b0;
    // Let the release be seen before the next access starts
    tick(2);
  endtask
  // Serial frame of n bits, MSB first; clock idles high
  task automatic ser(input logic rs, input logic [7:0] d, input int n);
    // strobe held high in serial mode
    BUS_STROBE = 1'b1;
    hd_r = 8'hFF;
    hd_en = 1'b1;
    tick(2);
    // select falls to start a clean frame
    CHIP_SEL_N = 1'b0;
    REG_SELECT = rs;
    for (int i = 7; i > 7 - n; i--) begin
      hd_r = {d[i], 1'b0, 6'h3F};
      tick(4);
      hd_r[6] = 1'b1;
      tick(4);
    end
    tick(4);
    CHIP_SEL_N = 1'b1;
    hd_en = 1'b0;
    tick(2);
  endtask
  // Hold a raw level on the pins
  task automatic pins(input logic [7:0] d);
    hd_r = d;
    hd_en = 1'b1;
    tick(4);
  endtask
endmodule

// file: testbench/lcd_ctrl_strap_host_select_tb.sv
// Self-checking bench for strap decode and host port block
`timescale 1ns/1ps
module lcd_ctrl_strap_host_select_tb;
  logic CLOCK, RESET_N, EXT_RESET_N, FOUR_BIT_BUS, BUSY, DUTY_HALF;
  logic BOOST_REQ, DOUBLE_FONT_REQ, REG_SELECT, READ_WRITE, BUS_STROBE;
  logic CHIP_SEL_N, CORE_RESET, INSTR_WR, DATA_WR, DATA_RD, I2C_SDA;
  logic I2C_SCL, PORT_INVALID, SER4_SEL, I2C_SEL, PAR_SEL, EXT_MODE;
  logic GLYPH_FROM_RAM, INT_OSC_SEL, BIAS_INVALID, BOOST_ON, ICON_RAM_EN;
  logic DOUBLE_FONT, OSC_TRIM_EN, CONTRAST_BY_INSTR, DDRAM_ADDR_OK;
  logic GLYPH_RAM_ADDR_OK;
  logic [3:0] SCAN_ROW, COM_ROW, RAM_GLYPHS;
  logic [6:0] ADDR_COUNTER, SCAN_COL, DDRAM_ADDR, SEG_COL;
  logic [7:0] HOST_DATA_IN, HOST_DATA_OUT, HOST_DATA_OE_N, READ_DATA;
  logic [7:0] CHAR_CODE, WR_DATA, q, oe;
  logic [5:0] GLYPH_RAM_ADDR;
  logic [8:0] ROM_GLYPHS, last_wr;  // last_wr: {data flag, byte}
  logic [15:0] COM_NONSEL;
  logic [1:0] BIAS_SEL;
  logic [9:0] st;                   // All straps in one vector
  logic [2:0] kb;                   // Strap pattern index
  wire EXTENSION_STRAP, PAR_SER_STRAP, SERIAL_KIND_STRAP;
  wire COMMON_DIR_STRAP, SEGMENT_DIR_STRAP, CLOCK_SOURCE_STRAP;
  wire [1:0] GLYPH_SPLIT_STRAPS, BIAS_SOURCE_STRAPS;
  int n_fail, compares, n_wr, n_rd, nw0, nr0;
  // ROM and RAM glyph counts per split code
  logic [12:0] gl [4] = '{13'h0F08, 13'h0FA6, 13'h0F88, 13'h1000};
  assign {EXTENSION_STRAP, PAR_SER_STRAP, SERIAL_KIND_STRAP,
    GLYPH_SPLIT_STRAPS, COMMON_DIR_STRAP, SEGMENT_DIR_STRAP,
    BIAS_SOURCE_STRAPS, CLOCK_SOURCE_STRAP} = st;
  lcd_ctrl_strap_host_select dut_u (.*);
  host_model host_u (.*);
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  // Pulse monitor; sees each registered pulse in its own cycle
  always @(posedge CLOCK) begin
    if (INSTR_WR === 1'b1 || DATA_WR === 1'b1) begin
      n_wr++;
      last_wr = {DATA_WR, WR_DATA};
    end
    if (DATA_RD === 1'b1) n_rd++;
  end
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Writes since last call and the last byte seen
  task automatic exp_wr(input int cnt, input logic [8:0] v);
    chk(16'(n_wr - nw0), 16'(cnt));
    if (cnt > 0) chk(16'(last_wr), 16'(v));
    nw0 = n_wr;
  endtask
  task automatic test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Straps held through reset, then inverted to prove they are frozen
  task automatic boot(input logic [9:0] s, input int n);
    @(negedge CLOCK);
    RESET_N = 1'b0;
    st = s;
    repeat (n) @(negedge CLOCK);
    RESET_N = 1'b1;
    @(negedge CLOCK);
    st = ~s;
  endtask
  initial begin
    #2000000;
    n_fail++;
    test_done();
  end
  initial begin
    {RESET_N, EXT_RESET_N, FOUR_BIT_BUS, BUSY, DUTY_HALF} = 5'h08;
    {BOOST_REQ, DOUBLE_FONT_REQ, st, ADDR_COUNTER} = 19'h0;
    {SCAN_ROW, SCAN_COL, CHAR_CODE, DDRAM_ADDR, GLYPH_RAM_ADDR} = 32'h0;
    {READ_DATA, n_fail, compares, n_wr, n_rd} = 0;
    // Every strap code, each under both feature sets
    for (int k = 0; k < 8; k++) begin
      kb = 3'(k);
      boot({kb[2], kb[1:0], kb[1:0], kb[0], kb[1], kb[1:0], kb[2]},
           k > 0 ? 4 : 16);
      DUTY_HALF = kb[0];
      SCAN_ROW = {1'b0, kb};
      SCAN_COL = {kb, 4'h0};
      CHAR_CODE = 8'h06;
      DDRAM_ADDR = 7'h4F + 7'(kb[0]);
      GLYPH_RAM_ADDR = 6'h3F;
      repeat (3) @(negedge CLOCK);
      chk({PORT_INVALID, SER4_SEL, I2C_SEL, PAR_SEL}, 4'h8 >> kb[1:0]);
      chk(EXT_MODE, !kb[2]);
      chk({ROM_GLYPHS, RAM_GLYPHS}, gl[kb[1:0]]);
      chk(GLYPH_FROM_RAM, gl[kb[1:0]][3:0] > 4'h6);
      chk(COM_ROW, kb[0] ? SCAN_ROW : 4'hF - SCAN_ROW);
      chk(SEG_COL, kb[1] ? SCAN_COL : 7'(7'h4F - SCAN_COL));
      chk(COM_NONSEL, kb[0] ? 16'hFF00 : 16'h0000);
      chk(INT_OSC_SEL, kb[2]);
      chk({BIAS_INVALID, BIAS_SEL}, {kb[2] && !kb[1:0], kb[1:0]});
      chk(CONTRAST_BY_INSTR, !kb[2] && !kb[1:0]);
      chk({DDRAM_ADDR_OK, GLYPH_RAM_ADDR_OK}, {!kb[0], 1'b1});
      for (int b = 1; b >= 0; b--) begin
        {BOOST_REQ, DOUBLE_FONT_REQ} = {2{b[0]}};
        repeat (3) @(negedge CLOCK);
        chk({BOOST_ON, ICON_RAM_EN, DOUBLE_FONT, OSC_TRIM_EN},
          {!kb[2] && b[0], !kb[2], !kb[2] && b[0], !kb[2]});
      end
    end
    // Parallel, 8-bit: both registers, both directions, refusal
    boot(10'h19B, 4);
    {BUSY, ADDR_COUNTER, READ_DATA} = 16'hAB5A;
    nw0 = n_wr;
    nr0 = n_rd;
    host_u.par(1'b0, 1'b0, 1'b0, 8'hA5, q, oe);
    exp_wr(1, 9'h0A5);
    host_u.par(1'b0, 1'b1, 1'b0, 8'h3C, q, oe);
    exp_wr(1, 9'h13C);
    host_u.par(1'b1, 1'b1, 1'b0, 8'h77, q, oe);
    exp_wr(0, 9'h000);
    host_u.par(1'b0, 1'b0, 1'b1, 8'h00, q, oe);
    chk({oe, q}, 16'h00AB);
    host_u.par(1'b0, 1'b1, 1'b1, 8'h00, q, oe);
    chk({oe, q}, 16'h005A);
    host_u.par(1'b1, 1'b1, 1'b1, 8'h00, q, oe);
    chk(oe, 8'hFF);
    chk(16'(n_rd - nr0), 16'h0001);
    // Parallel, 4-bit: low pins carry junk and must be ignored
    {FOUR_BIT_BUS, BUSY, ADDR_COUNTER} = 9'h14F;
    host_u.par(1'b0, 1'b1, 1'b0, 8'h9C, q, oe);
    exp_wr(0, 9'h000);
    host_u.par(1'b0, 1'b1, 1'b0, 8'h63, q, oe);
    exp_wr(1, 9'h196);
    host_u.par(1'b0, 1'b0, 1'b1, 8'h00, q, oe);
    chk({oe, q[7:4]}, 12'h0F4);
    host_u.par(1'b0, 1'b0, 1'b1, 8'h00, q, oe);
    chk({oe, q[7:4]}, 12'h0FF);
    FOUR_BIT_BUS = 1'b0;
    // Serial: a broken frame is dropped by the next select fall
    boot(10'h09B, 4);
    host_u.ser(1'b1, 8'hFF, 3);
    host_u.ser(1'b0, 8'hC3, 8);
    exp_wr(1, 9'h0C3);
    host_u.ser(1'b1, 8'h81, 8);
    exp_wr(1, 9'h181);
    // Two-wire: lines pass through, nothing is decoded
    boot(10'h11B, 4);
    host_u.ser(1'b0, 8'h5A, 8);
    exp_wr(0, 9'h000);
    host_u.pins(8'h7F);
    chk({I2C_SDA, I2C_SCL}, 2'h1);
    host_u.pins(8'hBF);
    chk({I2C_SDA, I2C_SCL}, 2'h2);
    // Invalid port code accepts nothing
    boot(10'h01B, 4);
    host_u.par(1'b0, 1'b1, 1'b0, 8'h11, q, oe);
    exp_wr(0, 9'h000);
    // External reset pin; straps (now inverted) are resampled
    EXT_RESET_N = 1'b0;
    repeat (6) @(negedge CLOCK);
    chk(CORE_RESET, 1'b1);
    EXT_RESET_N = 1'b1;
    repeat (6) @(negedge CLOCK);
    chk({CORE_RESET, PAR_SEL}, 2'h1);
    test_done();
  end
endmodule
